// *** hw/power_manager_status_control.sv ***
// Power manager event, status, generic clock, reset origin and keyed setup registers.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module power_manager_status_control
  import pm_status_pkg::*;
#(
  parameter int NUM_GCLK = 4
)(
  // Clock and reset.
  input  wire logic                   clk,
  input  wire logic                   srst,
  // Register port.
  input  wire logic [ADDR_W-1:0]      addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic [31:0]                 rdata,
  // Analog indicators, asynchronous: pll1, pll0 lock.
  input  wire logic [1:0]             pll_lock_raw,
  input  wire logic                   osc0_ready_raw,
  input  wire logic                   osc1_ready_raw,
  input  wire logic                   osc32_ready_raw,
  input  wire logic                   brownout_raw,
  // PLL settle control, same clock.
  input  wire logic [1:0]             pll_ctrl_written,
  input  wire logic [2*SETTLE_W-1:0]  pll_settle_count,
  input  wire logic                   slow_tick,
  // Clock switch and gating handshakes, same clock.
  input  wire logic                   clock_select_written,
  input  wire logic                   clock_switch_ack,
  input  wire logic                   mask_changed,
  input  wire logic                   mask_applied,
  // Source ticks for generic clocks: osc0, osc1, pll0, pll1.
  input  wire logic [3:0]             src_tick,
  // Reset causes, held during srst.
  input  wire logic [9:0]             reset_cause_in,
  // Fuse loading.
  input  wire logic                   fuse_load,
  input  wire logic [1:0]             fuse_bod_action,
  input  wire logic                   fuse_bod_brownout_hysteresis,
  input  wire logic [BOD_LEVEL_W-1:0] fuse_bod_level,
  input  wire logic [TRIM_W-1:0]      fuse_trim,
  // Outputs.
  output logic [NUM_GCLK-1:0]         gen_clock_tick,
  output logic                        brownout_reset_req,
  output logic                        brownout_alert,
  output logic                        brownout_hysteresis,
  output logic [BOD_LEVEL_W-1:0]      brownout_level,
  output logic [TRIM_W-1:0]           trim_value
);
  if (NUM_GCLK < 1 || NUM_GCLK > 8) begin : g_bad_count
    $error("NUM_GCLK must be 1 to 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for asynchronous indicators.
  logic [5:0] raw_s1;
  logic [5:0] raw_s2;
  wire  logic [5:0] raw_in = {brownout_raw, osc32_ready_raw, osc1_ready_raw,
                              osc0_ready_raw, pll_lock_raw};

  always_ff @(posedge clk) begin
    if (srst) begin
      raw_s1 <= '0;
      raw_s2 <= '0;
    end else begin
      raw_s1 <= raw_in;
      raw_s2 <= raw_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PLL settle counters, in slow clock ticks.
  logic [1:0][SETTLE_W-1:0] settle;

  for (genvar p = 0; p < 2; p++) begin : g_pll
    always_ff @(posedge clk) begin
      if (srst) begin
        settle[p] <= '0;
      end else if (pll_ctrl_written[p]) begin
        settle[p] <= pll_settle_count[p*SETTLE_W +: SETTLE_W];
      end else if (slow_tick && settle[p] != '0) begin
        settle[p] <= settle[p] - 1'b1;
      end
    end
  end

  wire logic pll0_locked = raw_s2[0] && settle[0] == '0 && !pll_ctrl_written[0];
  wire logic pll1_locked = raw_s2[1] && settle[1] == '0 && !pll_ctrl_written[1];

  ////////////////////////////////////////////////////////////////////////////
  // Clock switch and gating completion flags.
  logic clock_switch_done;
  logic gating_applied;

  always_ff @(posedge clk) begin
    if (srst) begin
      clock_switch_done <= 1'b1;
      gating_applied    <= 1'b1;
    end else begin
      // A new select write outranks an acknowledge of the previous one.
      if (clock_select_written) begin
        clock_switch_done <= 1'b0;
      end else if (clock_switch_ack) begin
        clock_switch_done <= 1'b1;
      end
      if (mask_changed) begin
        gating_applied <= 1'b0;
      end else if (mask_applied) begin
        gating_applied <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Keyed brownout and trim registers.
  logic [1:0]             bod_action;
  logic                   bod_fuse_done;
  logic                   trim_fuse_done;
  key_state_e             bod_key;
  key_state_e             trim_key;

  wire logic       brownout_on = bod_action == BOD_ACT_RESET || bod_action == BOD_ACT_ALERT;
  wire logic [7:0] key       = wdata[KEY_LSB +: 8];
  wire logic       wr_bod    = wr && addr == OFS_BROWNOUT;
  wire logic       wr_trim   = wr && addr == OFS_RC_TRIM;
  wire logic       bod_go    = wr_bod && bod_key == KEY_ARMED && key == KEY_SECOND;
  wire logic       trim_go   = wr_trim && trim_key == KEY_ARMED && key == KEY_SECOND;

  always_ff @(posedge clk) begin
    if (srst) begin
      bod_key  <= KEY_IDLE;
      trim_key <= KEY_IDLE;
    end else begin
      // Any write that is not the next key step restarts the sequence.
      if (wr_bod) begin
        bod_key <= (bod_key == KEY_IDLE && key == KEY_FIRST) ? KEY_ARMED : KEY_IDLE;
      end
      if (wr_trim) begin
        trim_key <= (trim_key == KEY_IDLE && key == KEY_FIRST) ? KEY_ARMED : KEY_IDLE;
      end
    end
  end

  // Reset is treated as power-on for fuse reload purposes.
  always_ff @(posedge clk) begin
    if (srst) begin
      bod_action          <= '0;
      brownout_hysteresis <= 1'b0;
      brownout_level      <= '0;
      bod_fuse_done       <= 1'b0;
    end else if (bod_go) begin
      bod_action          <= wdata[BOD_CTRL_LSB +: 2];
      brownout_hysteresis <= wdata[BOD_BROWNOUT_HYSTERESIS_BIT];
      brownout_level      <= wdata[BOD_LEVEL_W-1:0];
      bod_fuse_done       <= wdata[FUSE_DONE_BIT];
    end else if (fuse_load && !bod_fuse_done) begin
      bod_action          <= fuse_bod_action;
      brownout_hysteresis <= fuse_bod_brownout_hysteresis;
      brownout_level      <= fuse_bod_level;
      bod_fuse_done       <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      trim_value     <= '0;
      trim_fuse_done <= 1'b0;
    end else if (trim_go) begin
      trim_value     <= wdata[TRIM_W-1:0];
      trim_fuse_done <= wdata[FUSE_DONE_BIT];
    end else if (fuse_load && !trim_fuse_done) begin
      trim_value     <= fuse_trim;
      trim_fuse_done <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Live status word and pending events.
  logic [31:0] status_q;
  logic [31:0] pending;
  logic [31:0] irq_en;
  wire  logic  bod_detect = raw_s2[5] && brownout_on;
  logic [31:0] status;

  always_comb begin
    status             = '0;
    status[B_PLL0]     = pll0_locked;
    status[B_PLL1]     = pll1_locked;
    status[B_CLK_DONE] = clock_switch_done;
    status[B_GATING]   = gating_applied;
    status[B_OSC0]     = raw_s2[2];
    status[B_OSC1]     = raw_s2[3];
    status[B_OSC32]    = raw_s2[4];
    status[B_BOD]      = bod_detect;
  end

  wire logic [31:0] rise    = status & ~status_q & EVT_MASK;
  wire logic [31:0] clr_req = (wr && addr == OFS_EVT_CLR) ? wdata : '0;
  wire logic [31:0] clr     = clr_req & EVT_MASK & ~(32'h1 << B_CLK_DONE);
  wire logic [31:0] en_set  = (wr && addr == OFS_EN_SET) ? wdata & EVT_MASK : '0;
  wire logic [31:0] en_clr  = (wr && addr == OFS_EN_CLR) ? wdata : '0;

  always_ff @(posedge clk) begin
    if (srst) begin
      status_q <= '0;
      pending  <= '0;
      irq_en   <= '0;
    end else begin
      status_q <= status;
      pending  <= (pending & ~clr) | rise;
      irq_en   <= (irq_en | en_set) & ~en_clr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Brownout actions.
  always_ff @(posedge clk) begin
    if (srst) begin
      brownout_reset_req <= 1'b0;
      brownout_alert     <= 1'b0;
    end else begin
      brownout_reset_req <= bod_detect && bod_action == BOD_ACT_RESET;
      brownout_alert     <= pending[B_BOD] && irq_en[B_BOD] && bod_action == BOD_ACT_ALERT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset origin, caught while reset is held.
  logic [31:0] reset_origin;

  always_ff @(posedge clk) begin
    if (srst) begin
      reset_origin <= {22'h0, reset_cause_in} & RST_ORIGIN_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Generic clocks.
  logic [NUM_GCLK-1:0][GC_W-1:0] gclk_setup;
  logic [31:0]                   gclk_rd;

  for (genvar g = 0; g < NUM_GCLK; g++) begin : g_gclk
    wire logic hit = addr == OFS_GCLK_BASE + 8'(4 * g);
    always_ff @(posedge clk) begin
      if (srst) begin
        gclk_setup[g] <= '0;
      end else if (wr && hit) begin
        gclk_setup[g] <= wdata[GC_W-1:0] & 16'hFF17;
      end
    end
    gen_clock_divider u_div (
      .clk               (clk),
      .srst              (srst),
      .src_tick          (src_tick),
      .gen_clock_run     (gclk_setup[g][GC_RUN_BIT]),
      .source_type_pick  (gclk_setup[g][GC_TYPE_BIT]),
      .source_index_pick (gclk_setup[g][GC_INDEX_BIT]),
      .ratio_apply       (gclk_setup[g][GC_APPLY_BIT]),
      .ratio             (gclk_setup[g][GC_RATIO_LSB +: GC_RATIO_W]),
      .gen_tick          (gen_clock_tick[g])
    );
  end

  wire logic [7:0] gidx = 8'(addr - OFS_GCLK_BASE) >> 2;
  wire logic       gsel = addr >= OFS_GCLK_BASE && addr[1:0] == 2'h0 &&
                          gidx < 8'(NUM_GCLK);
  assign gclk_rd = gsel ? {16'h0, gclk_setup[gidx[2:0]]} : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Read port; unmapped and write-only addresses read zero.
  logic [31:0] rd_mux;

  always_comb begin
    unique case (addr)
      OFS_EN_VIEW:    rd_mux = irq_en;
      OFS_PENDING:    rd_mux = pending;
      OFS_STATUS:     rd_mux = status;
      OFS_RST_ORIGIN: rd_mux = reset_origin;
      OFS_BROWNOUT:   rd_mux = {15'h0, bod_fuse_done, 6'h0, bod_action, 1'b0,
                                brownout_hysteresis, brownout_level};
      OFS_RC_TRIM:    rd_mux = {15'h0, trim_fuse_done, 6'h0, trim_value};
      default:        rd_mux = gclk_rd;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= '0;
    end else begin
      rdata <= rd ? rd_mux : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_rise_sets;
    @(posedge clk) disable iff (srst)
    (!srst && rise != '0) |=> ((pending & $past(rise)) == $past(rise));
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rise did not set pending");

  property p_clear_event;
    @(posedge clk) disable iff (srst)
    (wr && addr == OFS_EVT_CLR && wdata[B_OSC0] && !rise[B_OSC0]) |=> !pending[B_OSC0];
  endproperty
  a_clear_event: assert property (p_clear_event) else $error("clear ignored");

  property p_clk_done_kept;
    @(posedge clk) disable iff (srst)
    (pending[B_CLK_DONE] && clr_req[B_CLK_DONE]) |=> pending[B_CLK_DONE];
  endproperty
  a_clk_done_kept: assert property (p_clk_done_kept) else $error("clock event cleared");

  property p_enable_pair;
    @(posedge clk) disable iff (srst)
    (wr && addr == OFS_EN_SET && wdata[B_PLL0]) |=> irq_en[B_PLL0] ##1
      ($past(en_clr[B_PLL0]) ? !irq_en[B_PLL0] : 1'b1);
  endproperty
  a_enable_pair: assert property (p_enable_pair) else $error("enable not held");

  property p_switch_drop;
    @(posedge clk) disable iff (srst)
    clock_select_written |=> !clock_switch_done ##1
      (!status[B_CLK_DONE] || $past(clock_switch_ack));
  endproperty
  a_switch_drop: assert property (p_switch_drop) else $error("switch flag held");

  property p_gating_drop;
    @(posedge clk) disable iff (srst)
    mask_changed |=> !gating_applied;
  endproperty
  a_gating_drop: assert property (p_gating_drop) else $error("gating flag held");

  property p_lock_wait;
    @(posedge clk) disable iff (srst)
    (pll_ctrl_written[0] && pll_settle_count[SETTLE_W-1:0] != '0) |=> !status[B_PLL0];
  endproperty
  a_lock_wait: assert property (p_lock_wait) else $error("lock too early");

  property p_key_discard;
    @(posedge clk) disable iff (srst)
    (wr_bod && bod_key == KEY_IDLE && !fuse_load) |=> $stable(bod_action) && $stable(brownout_level);
  endproperty
  a_key_discard: assert property (p_key_discard) else $error("unkeyed write applied");

  property p_fuse_once;
    @(posedge clk) disable iff (srst)
    (fuse_load && trim_fuse_done && !trim_go) |=> $stable(trim_value);
  endproperty
  a_fuse_once: assert property (p_fuse_once) else $error("fuse reloaded trim");

  property p_bod_reset;
    @(posedge clk) disable iff (srst)
    brownout_reset_req |-> $past(bod_action) == BOD_ACT_RESET && $past(raw_s2[5]);
  endproperty
  a_bod_reset: assert property (p_bod_reset) else $error("bad brownout reset");

  property p_origin_hold;
    @(posedge clk) disable iff (srst)
    !srst |=> $stable(reset_origin) && (reset_origin & ~RST_ORIGIN_MASK) == '0;
  endproperty
  a_origin_hold: assert property (p_origin_hold) else $error("reset origin moved");
endmodule

// *** hw/pm_status_pkg.sv ***
// Constants shared by the power manager status and control logic.
package pm_status_pkg;
  localparam int        ADDR_W          = 8;
  localparam bit [7:0]  OFS_EN_SET      = 8'h00;
  localparam bit [7:0]  OFS_EN_CLR      = 8'h04;
  localparam bit [7:0]  OFS_EN_VIEW     = 8'h08;
  localparam bit [7:0]  OFS_PENDING     = 8'h0C;
  localparam bit [7:0]  OFS_EVT_CLR     = 8'h10;
  localparam bit [7:0]  OFS_STATUS      = 8'h14;
  localparam bit [7:0]  OFS_RST_ORIGIN  = 8'h18;
  localparam bit [7:0]  OFS_BROWNOUT    = 8'h1C;
  localparam bit [7:0]  OFS_RC_TRIM     = 8'h20;
  localparam bit [7:0]  OFS_GCLK_BASE   = 8'h40;
  // Event and status bit positions.
  localparam int        B_PLL0          = 0;
  localparam int        B_PLL1          = 1;
  localparam int        B_CLK_DONE      = 5;
  localparam int        B_GATING        = 6;
  localparam int        B_OSC0          = 7;
  localparam int        B_OSC1          = 8;
  localparam int        B_OSC32         = 9;
  localparam int        B_BOD           = 16;
  localparam bit [31:0] EVT_MASK        = 32'h0001_03E3;
  localparam bit [31:0] RST_ORIGIN_MASK = 32'h0000_039F;
  // Key field and values.
  localparam int        KEY_LSB         = 24;
  localparam bit [7:0]  KEY_FIRST       = 8'h55;
  localparam bit [7:0]  KEY_SECOND      = 8'hAA;
  localparam int        FUSE_DONE_BIT   = 16;
  // Brownout field layout.
  localparam int        BOD_CTRL_LSB    = 8;
  localparam int        BOD_BROWNOUT_HYSTERESIS_BIT    = 6;
  localparam int        BOD_LEVEL_W     = 6;
  localparam bit [1:0]  BOD_ACT_RESET   = 2'h1;
  localparam bit [1:0]  BOD_ACT_ALERT   = 2'h2;
  localparam int        TRIM_W          = 10;
  // Generic clock field layout.
  localparam int        GC_INDEX_BIT    = 0;
  localparam int        GC_TYPE_BIT     = 1;
  localparam int        GC_RUN_BIT      = 2;
  localparam int        GC_APPLY_BIT    = 4;
  localparam int        GC_RATIO_LSB    = 8;
  localparam int        GC_RATIO_W      = 8;
  localparam int        GC_W            = 16;
  localparam int        SETTLE_W        = 4;
  typedef enum logic [0:0] {KEY_IDLE, KEY_ARMED} key_state_e;
endpackage

// *** hw/gen_clock_divider.sv ***
// One generic clock: source pick, run gate and ratio divider on tick pulses.
`timescale 1ns/1ps
module gen_clock_divider
  import pm_status_pkg::*;
(
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  srst,
  // Source ticks: osc0, osc1, pll0, pll1.
  input  wire logic [3:0]            src_tick,
  // Setup fields.
  input  wire logic                  gen_clock_run,
  input  wire logic                  source_type_pick,
  input  wire logic                  source_index_pick,
  input  wire logic                  ratio_apply,
  input  wire logic [GC_RATIO_W-1:0] ratio,
  // Generated tick.
  output logic                       gen_tick
);
  logic [GC_RATIO_W:0] cnt;
  wire  logic          pick = src_tick[{source_type_pick, source_index_pick}];
  wire  logic [GC_RATIO_W:0] last = {ratio, 1'b1};

  always_ff @(posedge clk) begin
    if (srst || !gen_clock_run) begin
      cnt      <= '0;
      gen_tick <= 1'b0;
    end else if (!pick) begin
      gen_tick <= 1'b0;
    end else if (!ratio_apply) begin
      gen_tick <= 1'b1;
    end else begin
      // Counts 2*(ratio+1) source ticks per output tick.
      gen_tick <= (cnt == last);
      cnt      <= (cnt == last) ? '0 : cnt + 1'b1;
    end
  end
endmodule

// *** tb/power_manager_status_control_tb.sv ***
// Self-checking bench for the power manager status and control block.
`timescale 1ns/1ps
module power_manager_status_control_tb
  import pm_status_pkg::*;
;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic [7:0]        addr = 8'h00;
  logic [31:0]       wdata = 32'h0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [31:0]       rdata;
  logic [1:0]        pll_lock_raw = 2'h0;
  logic [2:0]        osc_raw = 3'h0;
  logic              brownout_raw = 1'b0;
  logic [1:0]        pll_ctrl_written = 2'h0;
  logic [7:0]        pll_settle_count = 8'h00;
  logic              slow_tick = 1'b0;
  logic [3:0]        hs = 4'h0;
  logic [3:0]        src_tick = 4'h0;
  logic [9:0]        reset_cause_in = 10'h3FF;
  logic              fuse_load = 1'b0;
  logic [1:0]        fuse_bod_action = 2'h0;
  logic              fuse_bod_brownout_hysteresis = 1'b1;
  logic [5:0]        fuse_bod_level = 6'h15;
  logic [9:0]        fuse_trim = 10'h2C3;
  logic [1:0]        gen_clock_tick;
  logic              brownout_reset_req;
  logic              brownout_alert;
  logic              brownout_hysteresis;
  logic [5:0]        brownout_level;
  logic [9:0]        trim_value;
  int                err_total = 0;
  int                n_checks = 0;

  always #4 clk = ~clk;

  power_manager_status_control #(.NUM_GCLK(2)) u_power_manager_status_control (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pll_lock_raw(pll_lock_raw), .osc0_ready_raw(osc_raw[0]), .osc1_ready_raw(osc_raw[1]),
    .osc32_ready_raw(osc_raw[2]), .brownout_raw(brownout_raw),
    .pll_ctrl_written(pll_ctrl_written), .pll_settle_count(pll_settle_count),
    .slow_tick(slow_tick), .clock_select_written(hs[0]), .clock_switch_ack(hs[1]),
    .mask_changed(hs[2]), .mask_applied(hs[3]), .src_tick(src_tick),
    .reset_cause_in(reset_cause_in), .fuse_load(fuse_load),
    .fuse_bod_action(fuse_bod_action), .fuse_bod_brownout_hysteresis(fuse_bod_brownout_hysteresis),
    .fuse_bod_level(fuse_bod_level), .fuse_trim(fuse_trim),
    .gen_clock_tick(gen_clock_tick), .brownout_reset_req(brownout_reset_req),
    .brownout_alert(brownout_alert), .brownout_hysteresis(brownout_hysteresis),
    .brownout_level(brownout_level), .trim_value(trim_value));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
    @(posedge clk) wr <= 1'b0;
  endtask

  // Both key writes go back to back so nothing can disarm the sequence between them.
  task automatic key_wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= {KEY_FIRST, 24'h0}; end
    @(posedge clk) wdata <= {KEY_SECOND, d};
    @(posedge clk) wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk) begin rd <= 1'b1; addr <= a; end
    @(posedge clk) rd <= 1'b0;
    #1 chk(rdata & m, e);
  endtask

  task automatic pulse_hs(input int i);
    @(posedge clk) hs[i] <= 1'b1;
    @(posedge clk) hs[i] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic gclk_case(input int i, input logic [15:0] s, input logic [3:0] m, input int e);
    int cnt;
    cnt = 0;
    wr_reg(OFS_GCLK_BASE + 8'(4 * i), 32'h0);
    wr_reg(OFS_GCLK_BASE + 8'(4 * i), {16'h0, s});
    rd_chk(OFS_GCLK_BASE + 8'(4 * i), 32'h0000_FF17, {16'h0, s});
    for (int c = 0; c < 28; c++) begin
      @(posedge clk) src_tick <= (c < 24) ? m : 4'h0;
      #1 if (gen_clock_tick[i] !== 1'b0) cnt++;
    end
    chk(32'(cnt), 32'(e));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done();
  end

  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    reset_cause_in <= 10'h000;
    repeat (4) @(posedge clk);
    rd_chk(OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0060);
    rd_chk(OFS_PENDING, 32'hFFFF_FFFF, 32'h0000_0060);
    rd_chk(OFS_EN_VIEW, 32'hFFFF_FFFF, 32'h0);
    rd_chk(OFS_RST_ORIGIN, 32'hFFFF_FFFF, 32'h0000_039F);
    rd_chk(8'h3C, 32'hFFFF_FFFF, 32'h0);
    rd_chk(OFS_EN_SET, 32'hFFFF_FFFF, 32'h0);
    wr_reg(OFS_EVT_CLR, 32'hFFFF_FFFF);
    rd_chk(OFS_PENDING, 32'hFFFF_FFFF, 32'h0000_0020);
    wr_reg(OFS_EN_SET, 32'hFFFF_FFFF);
    rd_chk(OFS_EN_VIEW, 32'hFFFF_FFFF, EVT_MASK);
    wr_reg(OFS_EN_CLR, 32'h0000_0001);
    rd_chk(OFS_EN_VIEW, 32'hFFFF_FFFF, EVT_MASK & ~32'h1);
    wr_reg(OFS_STATUS, 32'h0);
    rd_chk(OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0060);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) osc_raw[i] <= 1'b1;
      repeat (5) @(posedge clk);
      rd_chk(OFS_STATUS, 32'h0000_0380, 32'h0000_0080 << i);
      rd_chk(OFS_PENDING, 32'h0000_0080 << i, 32'h0000_0080 << i);
      @(posedge clk) osc_raw[i] <= 1'b0;
    end
    repeat (5) @(posedge clk);
    rd_chk(OFS_PENDING, 32'h0000_0380, 32'h0000_0380);
    wr_reg(OFS_EVT_CLR, 32'h0000_0040);
    pulse_hs(0);
    rd_chk(OFS_STATUS, 32'h0000_0060, 32'h0000_0040);
    pulse_hs(1);
    rd_chk(OFS_STATUS, 32'h0000_0060, 32'h0000_0060);
    pulse_hs(2);
    rd_chk(OFS_STATUS, 32'h0000_0060, 32'h0000_0020);
    pulse_hs(3);
    rd_chk(OFS_STATUS, 32'h0000_0060, 32'h0000_0060);
    rd_chk(OFS_PENDING, 32'h0000_0040, 32'h0000_0040);
    @(posedge clk) begin pll_settle_count <= 8'h32; pll_lock_raw <= 2'h3; end
    @(posedge clk) pll_ctrl_written <= 2'h3;
    @(posedge clk) pll_ctrl_written <= 2'h0;
    repeat (5) @(posedge clk);
    rd_chk(OFS_STATUS, 32'h0000_0003, 32'h0);
    repeat (5) begin
      @(posedge clk) slow_tick <= 1'b1;
      @(posedge clk) slow_tick <= 1'b0;
    end
    repeat (4) @(posedge clk);
    rd_chk(OFS_STATUS, 32'h0000_0003, 32'h0000_0003);
    rd_chk(OFS_PENDING, 32'h0000_0003, 32'h0000_0003);
    @(posedge clk) fuse_load <= 1'b1;
    @(posedge clk) fuse_load <= 1'b0;
    rd_chk(OFS_BROWNOUT, 32'h0001_FFFF, 32'h0001_0055);
    rd_chk(OFS_RC_TRIM, 32'h0001_FFFF, 32'h0001_02C3);
    chk({25'h0, brownout_hysteresis, brownout_level}, 32'h55);
    @(posedge clk) begin fuse_bod_level <= 6'h0A; fuse_trim <= 10'h111; fuse_load <= 1'b1; end
    @(posedge clk) fuse_load <= 1'b0;
    rd_chk(OFS_BROWNOUT, 32'h0001_FFFF, 32'h0001_0055);
    rd_chk(OFS_RC_TRIM, 32'h0001_FFFF, 32'h0001_02C3);
    wr_reg(OFS_RC_TRIM, {KEY_SECOND, 24'h000155});
    rd_chk(OFS_RC_TRIM, 32'h0001_FFFF, 32'h0001_02C3);
    key_wr(OFS_RC_TRIM, 24'h000155);
    rd_chk(OFS_RC_TRIM, 32'h0001_FFFF, 32'h0000_0155);
    chk({22'h0, trim_value}, 32'h155);
    @(posedge clk) fuse_load <= 1'b1;
    @(posedge clk) fuse_load <= 1'b0;
    rd_chk(OFS_RC_TRIM, 32'h0001_FFFF, 32'h0001_0111);
    @(posedge clk) brownout_raw <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      // The level moves only on the first pass, while the written action keeps the detector off on passes 0 and 3.
      key_wr(OFS_BROWNOUT, 24'h01_002A | (24'(k) << 8));
      repeat (5) @(posedge clk);
      rd_chk(OFS_BROWNOUT, 32'h0001_FFFF, 32'h0001_002A | (32'(k) << 8));
      chk({24'h0, brownout_hysteresis, 1'b0, brownout_level}, 32'h2A);
      chk({31'h0, brownout_reset_req}, 32'(k == 1));
      chk({31'h0, brownout_alert}, 32'(k == 2));
      rd_chk(OFS_STATUS, 32'h0001_0000, 32'(k == 1 || k == 2) << 16);
      if (k == 2) begin
        wr_reg(OFS_EVT_CLR, 32'h0001_0000);
        repeat (2) @(posedge clk);
        chk({31'h0, brownout_alert}, 32'h0);
      end
    end
    gclk_case(0, 16'h0004, 4'h1, 24);
    gclk_case(1, 16'h0004, 4'hE, 0);
    gclk_case(0, 16'h0007, 4'h8, 24);
    gclk_case(1, 16'h0007, 4'h7, 0);
    gclk_case(0, 16'h0005, 4'h2, 24);
    gclk_case(1, 16'h0006, 4'h4, 24);
    gclk_case(0, 16'h0014, 4'h1, 12);
    gclk_case(1, 16'h0214, 4'h1, 4);
    gclk_case(0, 16'h0003, 4'hF, 0);
    test_done();
  end
endmodule
